// ==== smbme_pkg.sv ====
// Purpose: shared constants and carriers of the two-wire bus engine
// Assumes: included before every engine module
// Notes: states, phases and event codes live here so the bench can decode them
`default_nettype none
package smbme_pkg;
    localparam logic [3:0] FREE_TICKS = 4'ha;
    localparam logic [1:0] HIGH_LAST = 2'h1;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int unsigned RW_BIT = 0;
    localparam int unsigned ADDR_MSB = 7;
    localparam int unsigned ADDR_LSB = 1;
    localparam int unsigned DATA_MSB = 7;
    localparam logic [7:0] READ_FILL = 8'hff;
    localparam logic [1:0] PH_PREP = 2'h0;
    localparam logic [1:0] PH_WAIT = 2'h1;
    localparam logic [1:0] PH_EDGE = 2'h2;
    localparam logic [1:0] PH_DATA = 2'h3;

    typedef enum logic [2:0] {
        EV_TX_DONE,
        EV_RX_BYTE,
        EV_ADDR_MATCH,
        EV_STOP_SEEN,
        EV_ARB_LOST
    } smbme_evt_code_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_XFER,
        ST_ACK,
        ST_HOLD,
        ST_STOP
    } smbme_state_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic read;
        logic ack;
        logic [7:0] data;
    } smbme_cmd_t;

    typedef struct packed {
        smbme_evt_code_t code;
        logic ack_rx;
        logic [7:0] data;
    } smbme_evt_t;

    typedef struct packed {
        logic enable;
        logic slave_inhibit;
        logic free_timeout_enable;
        logic low_timeout_enable;
        logic [1:0] clk_src;
        logic [6:0] own_addr;
    } smbme_cfg_t;

    localparam int unsigned CFG_W = $bits(smbme_cfg_t);
endpackage
`default_nettype wire

// ==== smbme_sync.sv ====
// Purpose: three-stage synchroniser with agreement filter
// Assumes: d comes from another clock domain or a pin
// Notes: a bit of the output moves only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module smbme_sync import smbme_pkg::*; #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] stable_q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // disagreeing stages keep the old value, so one metastable sample never counts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stable_q <= INIT;
        end else begin
            stable_q <= (s2_q & s3_q) | (stable_q & (s2_q | s3_q));
        end
    end
endmodule // smbme_sync
`default_nettype wire

// ==== smbme_bus_monitor.sv ====
// Purpose: start/stop detection, bus busy tracking and timeout timer steering
// Assumes: scl_s and sda_s are already synchronised to clk
// Notes: tick is the selected bit-clock overflow pulse
`timescale 1ns/1ps
`default_nettype none
module smbme_bus_monitor import smbme_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_s,
    input wire logic sda_s,
    input wire logic tick,
    input wire logic free_to_en,
    input wire logic low_to_en,
    output logic scl_rise,
    output logic scl_fall,
    output logic start_seen,
    output logic stop_seen,
    output logic bus_busy_q,
    output logic low_reload_q,
    output logic low_count_q
);
    logic scl_p_q;
    logic sda_p_q;
    logic [3:0] free_cnt_q;
    logic idle_hi;

    assign idle_hi = scl_s && sda_s;
    assign scl_rise = !scl_p_q && scl_s;
    assign scl_fall = scl_p_q && !scl_s;
    assign start_seen = scl_p_q && scl_s && sda_p_q && !sda_s;
    assign stop_seen = scl_p_q && scl_s && !sda_p_q && sda_s;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // the first tick only opens a partial period, so the eleventh proves ten whole ones
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            free_cnt_q <= 4'h0;
            bus_busy_q <= 1'b0;
        end else begin
            if (!idle_hi) begin
                free_cnt_q <= 4'h0;
            end else if (tick && free_cnt_q != FREE_TICKS) begin
                free_cnt_q <= free_cnt_q + 4'h1;
            end
            if (start_seen) begin
                bus_busy_q <= 1'b1;
            end else if (stop_seen) begin
                bus_busy_q <= 1'b0;
            end else if (free_to_en && idle_hi && tick && free_cnt_q == FREE_TICKS) begin
                bus_busy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_reload_q <= 1'b0;
            low_count_q <= 1'b0;
        end else begin
            low_reload_q <= low_to_en && scl_s;
            low_count_q <= low_to_en && !scl_s;
        end
    end
endmodule // smbme_bus_monitor
`default_nettype wire

// ==== smbme_engine.sv ====
// Purpose: byte-wide master/slave engine for the two-wire SCL/SDA bus
// Assumes: link_clk clocks the bus side, sys_clk the processor side
// Notes: bit_src_ovf pulses are on link_clk; cfg is quasi-static
// Contract
// - bit rate up to a tenth of the system clock, master or slave
// - processor moves whole bytes; engine shifts the bits alone
// - acts as master, slave or both on a multi-master bus
// - one data register carries sent, received and address bytes
// - write sends bytes to a slave; read takes bytes from it
// - master starts every transfer and makes every SCL pulse
// - whoever sends START plus address is master for that transfer only
// - START, address in bits 7..1 with direction in bit 0, data, STOP
// - receiver acknowledges by holding SDA low while SCL is high
// - SDA high during the acknowledge bit reads as not-acknowledge
// - direction bit one means read, zero means write
// - in a write the master sends bytes and samples each acknowledge
// - in a read the slave sends bytes and samples each acknowledge
// - master ends with STOP, releasing the bus
// - master starts only on a free bus: after STOP or free timeout
// - master releasing SDA but seeing it low has lost arbitration
// - loser turns slave and still checks the address; winner unaffected
// - master waits for SCL really high before continuing a bit
// - lines are only pulled low or released, never driven high
// - free timeout: bus free after both lines high over ten ticks
// - event per byte: after ack when sending, before ack when receiving
// - low timeout: timer reloads while SCL high, counts while low
`timescale 1ns/1ps
`default_nettype none
module smbme_engine import smbme_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire smbme_cfg_t cfg,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire smbme_cmd_t cmd,
    output logic evt_valid_q,
    output smbme_evt_t evt_q,
    input wire logic [3:0] bit_src_ovf,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    output logic low_reload_q,
    output logic low_count_q
);
    // processor side
    logic req_tgl_q;
    smbme_cmd_t cmd_hold_q;
    logic [1:0] sys_sync_s;
    logic ack_s;
    logic evt_tgl_s;
    logic evt_seen_q;

    // link side
    logic [CFG_W:0] link_sync_s;
    logic req_s;
    smbme_cfg_t cfg_l;
    logic [1:0] pin_s;
    logic scl_s;
    logic sda_s;
    logic tick;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic bus_busy_q;
    logic req_pend;
    logic m_release;
    logic m_pull;
    logic m_count;

    smbme_state_t st_q;
    logic [1:0] ph_q;
    logic master_q;
    logic tx_q;
    logic addr_q;
    logic rd_q;
    logic ack_pend_q;
    logic stop_after_q;
    logic inh_q;
    logic ack_rx_q;
    logic [7:0] sh_q;
    logic [7:0] txbyte_q;
    logic [3:0] cnt_q;
    logic [1:0] hi_q;
    logic scl_drv_q;
    logic sda_drv_q;
    logic ack_tgl_q;
    logic evt_tgl_q;
    smbme_evt_t evt_hold_q;

    // ---------------- processor clock domain ----------------
    smbme_sync #(.W(2), .INIT(2'h0)) u_sys_sync (
        .clk(sys_clk),
        .rst(rst),
        .d({ack_tgl_q, evt_tgl_q}),
        .stable_q(sys_sync_s)
    );
    assign ack_s = sys_sync_s[1];
    assign evt_tgl_s = sys_sync_s[0];

    // one command in flight; ready returns once the link side has taken it
    assign cmd_ready = (req_tgl_q == ack_s);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            req_tgl_q <= 1'b0;
            cmd_hold_q <= '0;
        end else if (cmd_valid && cmd_ready) begin
            cmd_hold_q <= cmd;
            req_tgl_q <= ~req_tgl_q;
        end
    end

    // the event word is stable long before its toggle has crossed
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            evt_seen_q <= 1'b0;
            evt_valid_q <= 1'b0;
            evt_q <= '0;
        end else begin
            evt_seen_q <= evt_tgl_s;
            evt_valid_q <= (evt_tgl_s != evt_seen_q);
            if (evt_tgl_s != evt_seen_q) begin
                evt_q <= evt_hold_q;
            end
        end
    end

    // ---------------- link clock domain ----------------
    smbme_sync #(.W(CFG_W + 1), .INIT('0)) u_link_sync (
        .clk(link_clk),
        .rst(rst),
        .d({req_tgl_q, cfg}),
        .stable_q(link_sync_s)
    );
    assign req_s = link_sync_s[CFG_W];
    assign cfg_l = smbme_cfg_t'(link_sync_s[CFG_W-1:0]);
    assign req_pend = (req_s != ack_tgl_q);

    smbme_sync #(.W(2), .INIT(2'h3)) u_pin_sync (
        .clk(link_clk),
        .rst(rst),
        .d({scl_i, sda_i}),
        .stable_q(pin_s)
    );
    assign scl_s = pin_s[1];
    assign sda_s = pin_s[0];

    // ticks must be slower than the pin path latency, which bounds the bit rate
    assign tick = bit_src_ovf[cfg_l.clk_src];

    smbme_bus_monitor u_mon (
        .clk(link_clk),
        .rst(rst),
        .scl_s(scl_s),
        .sda_s(sda_s),
        .tick(tick),
        .free_to_en(cfg_l.free_timeout_enable),
        .low_to_en(cfg_l.low_timeout_enable),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_seen(start_seen),
        .stop_seen(stop_seen),
        .bus_busy_q(bus_busy_q),
        .low_reload_q(low_reload_q),
        .low_count_q(low_count_q)
    );

    // open drain: the output value is always low, only the enable moves
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_n = !scl_drv_q;
    assign sda_oe_n = !sda_drv_q;

    // master clock: low for one tick, then high for two ticks seen high
    assign m_release = master_q && scl_drv_q && tick;
    assign m_pull = master_q && !scl_drv_q && scl_s && tick && hi_q == HIGH_LAST;
    assign m_count = master_q && !scl_drv_q && scl_s && tick && hi_q != HIGH_LAST;

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
            ph_q <= PH_PREP;
            master_q <= 1'b0;
            tx_q <= 1'b0;
            addr_q <= 1'b0;
            rd_q <= 1'b0;
            ack_pend_q <= 1'b0;
            stop_after_q <= 1'b0;
            inh_q <= 1'b0;
            ack_rx_q <= 1'b0;
            sh_q <= 8'h00;
            txbyte_q <= 8'h00;
            cnt_q <= 4'h0;
            hi_q <= 2'h0;
            scl_drv_q <= 1'b0;
            sda_drv_q <= 1'b0;
            ack_tgl_q <= 1'b0;
            evt_tgl_q <= 1'b0;
            evt_hold_q <= '0;
        end else if (!cfg_l.enable) begin
            st_q <= ST_IDLE;
            master_q <= 1'b0;
            ack_pend_q <= 1'b0;
            scl_drv_q <= 1'b0;
            sda_drv_q <= 1'b0;
            if (req_pend) begin
                ack_tgl_q <= ~ack_tgl_q;
            end
        end else if (stop_seen && st_q != ST_IDLE && st_q != ST_STOP && st_q != ST_START) begin
            if (!master_q && !addr_q) begin
                evt_hold_q <= '{EV_STOP_SEEN, ack_rx_q, sh_q};
                evt_tgl_q <= ~evt_tgl_q;
            end
            st_q <= ST_IDLE;
            master_q <= 1'b0;
            ack_pend_q <= 1'b0;
            scl_drv_q <= 1'b0;
            sda_drv_q <= 1'b0;
        end else if (start_seen && st_q != ST_START) begin
            // a foreign start: listen for our address; inhibit applies from here on
            st_q <= ST_XFER;
            master_q <= 1'b0;
            tx_q <= 1'b0;
            addr_q <= 1'b1;
            cnt_q <= 4'h0;
            ack_pend_q <= 1'b0;
            inh_q <= cfg_l.slave_inhibit;
            scl_drv_q <= 1'b0;
            sda_drv_q <= 1'b0;
        end else begin
            if (st_q == ST_XFER || st_q == ST_ACK) begin
                if (!master_q) begin
                    scl_drv_q <= 1'b0;
                end else if (m_release) begin
                    scl_drv_q <= 1'b0;
                    hi_q <= 2'h0;
                end else if (m_pull) begin
                    scl_drv_q <= 1'b1;
                end else if (m_count) begin
                    hi_q <= hi_q + 2'h1;
                end
            end
            case (st_q)
                ST_IDLE: begin
                    scl_drv_q <= 1'b0;
                    sda_drv_q <= 1'b0;
                    master_q <= 1'b0;
                    if (req_pend) begin
                        ack_tgl_q <= ~ack_tgl_q;
                        if (cmd_hold_q.start) begin
                            sh_q <= cmd_hold_q.data;
                            ph_q <= PH_PREP;
                            st_q <= ST_START;
                        end
                    end
                end
                ST_START: begin
                    case (ph_q)
                        PH_PREP: begin
                            sda_drv_q <= 1'b0;
                            if (tick) begin
                                scl_drv_q <= 1'b0;
                                ph_q <= PH_WAIT;
                            end
                        end
                        PH_WAIT: begin
                            if (scl_s && sda_s && (master_q || !bus_busy_q) && tick) begin
                                sda_drv_q <= 1'b1;
                                master_q <= 1'b1;
                                ph_q <= PH_EDGE;
                            end
                        end
                        PH_EDGE: begin
                            if (tick) begin
                                scl_drv_q <= 1'b1;
                                ph_q <= PH_DATA;
                            end
                        end
                        default: begin
                            // change SDA only once SCL is seen low, keeping hold time
                            if (!scl_s) begin
                                sda_drv_q <= !sh_q[DATA_MSB];
                                tx_q <= 1'b1;
                                addr_q <= 1'b1;
                                cnt_q <= 4'h0;
                                hi_q <= 2'h0;
                                st_q <= ST_XFER;
                            end
                        end
                    endcase
                end
                ST_XFER: begin
                    if (scl_rise) begin
                        sh_q <= {sh_q[6:0], sda_s};
                        cnt_q <= cnt_q + 4'h1;
                        if (master_q && tx_q && !sda_drv_q && !sda_s) begin
                            master_q <= 1'b0;
                            tx_q <= 1'b0;
                            sda_drv_q <= 1'b0;
                            scl_drv_q <= 1'b0;
                            evt_hold_q <= '{EV_ARB_LOST, 1'b0, sh_q};
                            evt_tgl_q <= ~evt_tgl_q;
                            // past the address byte the loser cannot be addressed
                            if (!addr_q) begin
                                st_q <= ST_IDLE;
                            end
                        end
                    end else if (scl_fall) begin
                        if (cnt_q == BYTE_BITS) begin
                            if (tx_q) begin
                                sda_drv_q <= 1'b0;
                                st_q <= ST_ACK;
                            end else if (addr_q && !master_q) begin
                                if (sh_q[ADDR_MSB:ADDR_LSB] == cfg_l.own_addr && !inh_q) begin
                                    evt_hold_q <= '{EV_ADDR_MATCH, 1'b0, sh_q};
                                    evt_tgl_q <= ~evt_tgl_q;
                                    rd_q <= sh_q[RW_BIT];
                                    ack_pend_q <= 1'b1;
                                    st_q <= ST_HOLD;
                                end else begin
                                    st_q <= ST_IDLE;
                                end
                            end else begin
                                evt_hold_q <= '{EV_RX_BYTE, 1'b0, sh_q};
                                evt_tgl_q <= ~evt_tgl_q;
                                ack_pend_q <= 1'b1;
                                st_q <= ST_HOLD;
                            end
                        end else if (tx_q) begin
                            sda_drv_q <= !sh_q[DATA_MSB];
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_rise) begin
                        ack_rx_q <= !sda_s;
                    end else if (scl_fall) begin
                        cnt_q <= 4'h0;
                        addr_q <= 1'b0;
                        if (tx_q) begin
                            evt_hold_q <= '{EV_TX_DONE, ack_rx_q, sh_q};
                            evt_tgl_q <= ~evt_tgl_q;
                            if (!master_q && !ack_rx_q) begin
                                st_q <= ST_IDLE;
                            end else begin
                                st_q <= ST_HOLD;
                            end
                        end else begin
                            sda_drv_q <= 1'b0;
                            rd_q <= 1'b0;
                            if (master_q && stop_after_q) begin
                                ph_q <= PH_PREP;
                                st_q <= ST_STOP;
                            end else if (!master_q && rd_q) begin
                                tx_q <= 1'b1;
                                sh_q <= txbyte_q;
                                sda_drv_q <= !txbyte_q[DATA_MSB];
                                st_q <= ST_XFER;
                            end else begin
                                st_q <= ST_XFER;
                            end
                        end
                    end
                end
                ST_HOLD: begin
                    // clock-low extension while software decides
                    scl_drv_q <= 1'b1;
                    if (req_pend) begin
                        ack_tgl_q <= ~ack_tgl_q;
                        hi_q <= 2'h0;
                        if (master_q && cmd_hold_q.start && !ack_pend_q) begin
                            sh_q <= cmd_hold_q.data;
                            ph_q <= PH_PREP;
                            st_q <= ST_START;
                        end else if (master_q && cmd_hold_q.stop && !ack_pend_q) begin
                            ph_q <= PH_PREP;
                            st_q <= ST_STOP;
                        end else if (ack_pend_q) begin
                            sda_drv_q <= cmd_hold_q.ack;
                            stop_after_q <= cmd_hold_q.stop;
                            txbyte_q <= cmd_hold_q.data;
                            ack_pend_q <= 1'b0;
                            tx_q <= 1'b0;
                            st_q <= ST_ACK;
                        end else begin
                            tx_q <= !cmd_hold_q.read;
                            sh_q <= cmd_hold_q.read ? READ_FILL : cmd_hold_q.data;
                            sda_drv_q <= !cmd_hold_q.read && !cmd_hold_q.data[DATA_MSB];
                            cnt_q <= 4'h0;
                            st_q <= ST_XFER;
                        end
                    end
                end
                ST_STOP: begin
                    if (ph_q == PH_PREP) begin
                        sda_drv_q <= 1'b1;
                        if (tick) begin
                            scl_drv_q <= 1'b0;
                            ph_q <= PH_WAIT;
                        end
                    end else if (scl_s && tick) begin
                        sda_drv_q <= 1'b0;
                        master_q <= 1'b0;
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // smbme_engine
`default_nettype wire

// ==== smbme_engine_props.sv ====
// Purpose: port checks of smbme_engine
// Assumes: bound to the engine
// Notes: link signals are sampled on sys_clk
`timescale 1ns/1ps
`default_nettype none
module smbme_engine_props import smbme_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst,
    input wire smbme_cfg_t cfg,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic evt_valid_q,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe_n,
    input wire logic sda_o,
    input wire logic low_reload_q,
    input wire logic low_count_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_open; !scl_o && !sda_o; endproperty
    a_open: assert property (p_open) else $error("line driven high");
    property p_excl; !(low_reload_q && low_count_q); endproperty
    a_excl: assert property (p_excl) else $error("reload with count");
    property p_cnt; (!scl_i && cfg.low_timeout_enable) [*8] |-> low_count_q; endproperty
    a_cnt: assert property (p_cnt) else $error("no count");
    property p_rld; (scl_i && cfg.low_timeout_enable) [*8] |-> low_reload_q; endproperty
    a_rld: assert property (p_rld) else $error("no reload");
    property p_low; $fell(scl_oe_n) |=> !scl_oe_n [*3]; endproperty
    a_low: assert property (p_low) else $error("short low");
    property p_wait; scl_oe_n && !scl_i |=> scl_oe_n; endproperty
    a_wait: assert property (p_wait) else $error("ignored stretch");
    property p_evt; evt_valid_q |=> !evt_valid_q; endproperty
    a_evt: assert property (p_evt) else $error("long event");
    property p_take; cmd_valid && cmd_ready |=> !cmd_ready; endproperty
    a_take: assert property (p_take) else $error("ready held");
endmodule // smbme_engine_props
bind smbme_engine smbme_engine_props smbme_engine_props_inst (.sys_clk, .rst, .cfg, .cmd_valid, .cmd_ready,
    .evt_valid_q, .scl_i, .scl_o, .scl_oe_n, .sda_o, .low_reload_q, .low_count_q);
`default_nettype wire

// ==== smbme_slave_model.sv ====
// Purpose: behavioural slave on the wires
// Assumes: scl and sda are pulled-up levels
// Notes: slow stretches every SCL low phase
`timescale 1ns/1ps
`default_nettype none
module smbme_slave_model #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic slow,
    input wire logic [7:0] tx_byte,
    output logic scl_pull,
    output logic sda_pull,
    output logic [7:0] rx_q,
    output logic rx_tgl
);
    logic [3:0] b = 4'h0;
    logic [7:0] sh = 8'h00;
    logic sel = 1'b0, rd = 1'b0, first = 1'b1;
    initial {scl_pull, sda_pull, rx_q, rx_tgl} = '0;
    always @(sda) if (scl === 1'b1) {b, first, sel} = {4'h0, 1'b1, 1'b0};
    always @(posedge scl) begin
        if (b < 8) {sh, b} = {sh[6:0], sda, b + 4'h1};
        else if (rd && sda) sel = 1'b0;
    end
    always @(negedge scl) begin
        if (b == 8) begin
            if (first) {sel, rd} = {sh[7:1] == ADDR, sh[0]};
            if (sel && !first && !rd) {rx_q, rx_tgl} = {sh, !rx_tgl};
            sda_pull = sel && (first || !rd);
            {first, b} = {1'b0, 4'h9};
        end else begin
            if (b == 9) b = 4'h0;
            sda_pull = sel && rd && b < 8 && !tx_byte[3'h7 - b[2:0]];
        end
        if (slow) begin
            scl_pull = 1'b1;
            #400 scl_pull = 1'b0;
        end
    end
endmodule // smbme_slave_model
`default_nettype wire

// ==== smbme_engine_test.sv ====
// Purpose: self-checking bench for smbme_engine
// Assumes: one slave model on the wires
// Notes: events and bytes are matched from queues
`timescale 1ns/1ps
`default_nettype none
module smbme_engine_test import smbme_pkg::*;;
    logic sys_clk = 1'b0, link_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, slow = 1'b0;
    logic cmd_ready, evt_valid_q, scl_oe_n, sda_oe_n, m_scl, m_sda, rx_t;
    logic [7:0] tx_b = 8'h00, rx_b, bq[$];
    logic [3:0] ovf = 4'h0;
    smbme_cfg_t cfg;
    smbme_cmd_t cmd = '0;
    smbme_evt_t evt_q, eq[$];
    int n_errors = 0, compares = 0, cyc = 0, div = 0;
    wire scl = scl_oe_n & !m_scl;
    wire sda = sda_oe_n & !m_sda;
    always #12.5 sys_clk = !sys_clk;
    always #7.5 link_clk = !link_clk;
    always @(posedge link_clk) begin
        div <= div + 1;
        for (int i = 0; i < 4; i++) ovf[i] <= div % (8 + 2 * i) == 0;
    end
    smbme_engine smbme_engine_inst (.sys_clk, .rst, .link_clk, .cfg, .cmd_valid, .cmd_ready, .cmd,
        .evt_valid_q, .evt_q, .bit_src_ovf(ovf), .scl_i(scl), .scl_o(), .scl_oe_n, .sda_i(sda),
        .sda_o(), .sda_oe_n, .low_reload_q(), .low_count_q());
    smbme_slave_model smbme_slave_model_inst (.scl, .sda, .slow, .tx_byte(tx_b), .scl_pull(m_scl),
        .sda_pull(m_sda), .rx_q(rx_b), .rx_tgl(rx_t));
    task automatic tally_and_finish;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk_evt(input smbme_evt_t e);
        compares++;
        if ({evt_q.code, evt_q.data} !== {e.code, e.data} || (e.code == EV_TX_DONE && evt_q.ack_rx !== e.ack_rx)) begin
            n_errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, evt_q);
        end
    endtask
    task automatic chk_byte(input logic [7:0] e, input logic [7:0] a);
        compares++;
        if (a !== e) begin
            n_errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    // the engine says when it can take the next byte; the wait gives up after 9000 cycles
    task automatic go(input smbme_cmd_t c, input smbme_evt_t e, input logic ex);
        int k;
        k = 0;
        if (ex) eq.push_back(e);
        do begin
            @(negedge sys_clk);
            k++;
        end while (cmd_ready !== 1'b1 && k < 9000);
        @(posedge sys_clk);
        {cmd_valid, cmd} <= {1'b1, c};
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
    endtask
    always @(negedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish;
        end
        if (evt_valid_q === 1'b1) chk_evt(eq.pop_front());
    end
    // the byte and its toggle leave the model in one step, so let the byte settle first
    always @(rx_t) if (!rst) #1 chk_byte(bq.pop_front(), rx_b);
    initial begin
        logic [7:0] a, d;
        void'($urandom(32'h07ab1344));
        cfg = {1'b1, 1'b0, 1'b1, 1'b1, 2'($urandom), 7'h11};
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (8) @(posedge sys_clk);
        for (int t = 0; t < 4; t++) begin
            a = {t == 1 ? 7'h55 : 7'h2a, t[1]};
            d = 8'($urandom);
            slow <= t[0];
            tx_b <= d;
            go({4'h8, a}, {EV_TX_DONE, t != 1, a}, 1'b1);
            if (t[1]) go(12'h200, {EV_RX_BYTE, 1'b0, d}, 1'b1);
            else if (t == 0) begin
                bq.push_back(d);
                go({4'h0, d}, {EV_TX_DONE, 1'b1, d}, 1'b1);
            end
            go(12'h400, '0, 1'b0);
            wait (eq.size() == 0 && bq.size() == 0);
            $display("test %0d done", t);
        end
        tally_and_finish;
    end
endmodule // smbme_engine_test
`default_nettype wire
